//--- cwm_consts.svh
// Overview of operation
// - Sixteen identical calendars, each own activity bit
// - Mode word bit n-1: one weekly, zero monthly
// - Month mask bits 0-11 gate January-December
// - Monthly: day bits 0-30 select days 1-31
// - Weekly: day bits 16-22 select Sunday-Saturday
// - Weekly: bits 0-4 pick first..fourth, last occurrence
// - Weekdays and occurrences share one word, split ranges
// - No occurrence bits set means every week
// - Last means final weekday instance, fourth or fifth
// - Active only inside start/end slot, both modes
// - Start equal end covers the whole day
// - Start above end crosses midnight into next day
// - Activity bits readable as logic input terms
// - Four entries per calendar: month, day, start, end
// - Mode bits 14 and 15 select calendars 15, 16
`ifndef CWM_CONSTS_SVH
`define CWM_CONSTS_SVH

`define CWM_IDX_STATUS    14'h076B
`define CWM_IDX_MODE      14'h076C
`define CWM_IDX_CAL1      14'h076D
`define CWM_ENT_MONTH     2'h0
`define CWM_ENT_DAY       2'h1
`define CWM_ENT_START     2'h2
`define CWM_ENT_END       2'h3
`define CWM_MASK_MONTH    32'h0000_0FFF
`define CWM_MASK_DAY      32'h7FFF_FFFF
`define CWM_MASK_TIME     32'h0000_1F3F
`define CWM_MASK_MODE     32'h0000_FFFF
`define CWM_RST_CFG       32'h0000_0000
`define CWM_RST_MODE      16'h0000
`define CWM_WD_LSB        5'h10
`define CWM_OCC_LAST      3'h4
`define CWM_HOUR_LSB      8
`define CWM_MIN_PER_HOUR  11'h03C
`define CWM_DAYS_PER_WEEK 5'h07
`define CWM_STAT_EVAL_BIT 16
`define CWM_RESP_OKAY     2'h0
`define CWM_RESP_SLVERR   2'h2

`endif

//--- cwm_pkg.sv
package cwm_pkg;
   typedef logic [31:0] cwm_word_t;
   typedef logic [11:0] cwm_month_mask_t;
   typedef logic [10:0] cwm_minute_t;
   typedef struct packed {
      logic [6:0] year;
      logic [3:0] month;
      logic [4:0] day;
      logic [2:0] weekday;
      logic [4:0] hour;
      logic [5:0] minute;
   } cwm_datetime_t;
   typedef struct packed {
      cwm_month_mask_t month_mask;
      cwm_word_t       day_mask;
      cwm_word_t       start_time;
      cwm_word_t       end_time;
   } cwm_cal_cfg_t;
endpackage

//--- cwm_cal_eval.sv
`timescale 1ns/10ps
`include "cwm_consts.svh"
module cwm_cal_eval (
   input  wire logic                  weekly,
   input  wire cwm_pkg::cwm_cal_cfg_t cfg,
   input  wire cwm_pkg::cwm_datetime_t now,
   input  wire logic [4:0]            days_in_month,
   input  wire logic                  yest_sel,
   output wire logic                  day_sel,
   output wire logic                  active
);
   wire logic [15:0]          month_ext = {4'h0, cfg.month_mask};
   wire logic                 month_ok  = (now.month != 4'h0) & month_ext[now.month - 4'h1];
   wire logic [4:0]           dom_idx   = now.day - 5'h01;
   wire logic                 day_ok    = (now.day != 5'h00) & cfg.day_mask[dom_idx];
   wire logic [4:0]           wd_idx    = `CWM_WD_LSB + {2'h0, now.weekday};
   wire logic                 wd_ok     = cfg.day_mask[wd_idx];
   wire logic [4:0]           occ_field = cfg.day_mask[4:0];
   wire logic [4:0]           occ_num   = dom_idx / `CWM_DAYS_PER_WEEK;
   wire logic                 last_week = ({1'b0, now.day} + {1'b0, `CWM_DAYS_PER_WEEK}) > {1'b0, days_in_month};
   // Occurrences one to four by week number, last by distance to month end
   wire logic                 occ_nth   = (occ_num < 5'h04) & occ_field[occ_num[1:0]];
   wire logic                 occ_last  = occ_field[`CWM_OCC_LAST] & last_week;
   wire logic                 occ_ok    = (occ_field == 5'h00) | occ_nth | occ_last;
   assign day_sel = month_ok & (weekly ? (wd_ok & occ_ok) : day_ok);

   wire cwm_pkg::cwm_minute_t now_min   = 11'(now.hour) * `CWM_MIN_PER_HOUR + 11'(now.minute);
   wire cwm_pkg::cwm_minute_t start_min = 11'(cfg.start_time[12:`CWM_HOUR_LSB]) * `CWM_MIN_PER_HOUR
                                          + 11'(cfg.start_time[5:0]);
   wire cwm_pkg::cwm_minute_t end_min   = 11'(cfg.end_time[12:`CWM_HOUR_LSB]) * `CWM_MIN_PER_HOUR
                                          + 11'(cfg.end_time[5:0]);
   wire logic                 after_st  = now_min >= start_min;
   wire logic                 before_en = now_min < end_min;
   wire logic                 full_day  = start_min == end_min;
   wire logic                 same_day  = start_min < end_min;
   assign active = full_day ? day_sel :
                   same_day ? (day_sel & after_st & before_en) :
                   ((day_sel & after_st) | (yest_sel & before_en));
endmodule

//--- cwm_top.sv
`timescale 1ns/10ps
`include "cwm_consts.svh"
module cwm_top #(
   parameter int NUM_CAL = 16,
   parameter int ADDR_W  = 16
) (
   input  wire logic                  ref_clk,
   input  wire logic                  rst_n,
   input  wire logic                  ce,
   input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output      logic                  s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output      logic                  s_axi_wready,
   output      logic [1:0]            s_axi_bresp,
   output      logic                  s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [ADDR_W-1:0]     s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output      logic                  s_axi_arready,
   output      logic [31:0]           s_axi_rdata,
   output      logic [1:0]            s_axi_rresp,
   output      logic                  s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  time_valid,
   input  wire cwm_pkg::cwm_datetime_t now,
   output      logic [NUM_CAL-1:0]    calendar_active_terms
);
   localparam int NUM_ENT = 4 * NUM_CAL;

   // Mode word and status terms field are both 16 wide; wider would need a second mode word
   if (NUM_CAL < 1 || NUM_CAL > 16) begin : g_bad_cal
      $error("cwm_top: NUM_CAL must lie in 1..16");
   end
   if (ADDR_W < 16 || ADDR_W > 32) begin : g_bad_addr
      $error("cwm_top: ADDR_W must lie in 16..32");
   end

   // Register state
   cwm_pkg::cwm_word_t cfg_q [0:NUM_ENT-1];
   logic [15:0]        mode_q;
   logic [NUM_CAL-1:0] today_sel_q;
   logic [NUM_CAL-1:0] yest_sel_q;
   logic [8:0]         date_key_q;
   logic               evaluated_q;

   // Bus handshake state
   logic [ADDR_W-1:0]  aw_addr_q;
   logic               aw_full_q;
   cwm_pkg::cwm_word_t w_data_q;
   logic [3:0]         w_strb_q;
   logic               w_full_q;

   // Write decode
   wire logic [13:0]   wr_idx      = aw_addr_q[15:2];
   wire logic [13:0]   wr_ent_full = wr_idx - `CWM_IDX_CAL1;
   wire logic          wr_is_mode  = wr_idx == `CWM_IDX_MODE;
   wire logic          wr_is_cfg   = (wr_idx >= `CWM_IDX_CAL1) && (wr_ent_full < 14'(NUM_ENT));
   wire logic          wr_is_stat  = wr_idx == `CWM_IDX_STATUS;
   // Shift instead of a part-select, which would reverse at the 16-bit default
   wire logic          wr_hi_ok    = (32'(aw_addr_q) >> 16) == 32'h0000_0000;
   wire logic          wr_mapped   = wr_hi_ok & (wr_is_mode | wr_is_cfg | wr_is_stat);
   wire logic          do_write    = aw_full_q & w_full_q & ~s_axi_bvalid;
   wire logic [5:0]    wr_ent      = wr_ent_full[5:0];

   // Read decode
   wire logic [13:0]   rd_idx      = s_axi_araddr[15:2];
   wire logic [13:0]   rd_ent_full = rd_idx - `CWM_IDX_CAL1;
   wire logic          rd_is_mode  = rd_idx == `CWM_IDX_MODE;
   wire logic          rd_is_cfg   = (rd_idx >= `CWM_IDX_CAL1) && (rd_ent_full < 14'(NUM_ENT));
   wire logic          rd_is_stat  = rd_idx == `CWM_IDX_STATUS;
   wire logic          rd_hi_ok    = (32'(s_axi_araddr) >> 16) == 32'h0000_0000;
   wire logic          rd_mapped   = rd_hi_ok & (rd_is_mode | rd_is_cfg | rd_is_stat);
   wire logic          do_read     = s_axi_arvalid & s_axi_arready;
   wire logic [5:0]    rd_ent      = rd_ent_full[5:0];

   // Field mask per entry type keeps reserved bits at zero
   wire cwm_pkg::cwm_word_t wr_mask =
      (wr_ent[1:0] == `CWM_ENT_MONTH) ? `CWM_MASK_MONTH :
      (wr_ent[1:0] == `CWM_ENT_DAY)   ? `CWM_MASK_DAY   : `CWM_MASK_TIME;
   wire cwm_pkg::cwm_word_t strb_bits = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                                         {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
   wire cwm_pkg::cwm_word_t cfg_old   = cfg_q[wr_ent];
   wire cwm_pkg::cwm_word_t cfg_new   = ((cfg_old & ~strb_bits) | (w_data_q & strb_bits)) & wr_mask;
   wire logic [15:0]        mode_new  = (mode_q & ~strb_bits[15:0]) | (w_data_q[15:0] & strb_bits[15:0]);

   wire cwm_pkg::cwm_word_t status_word = {15'h0000, evaluated_q, 16'(calendar_active_terms)};
   wire cwm_pkg::cwm_word_t rd_word =
      rd_is_mode ? {16'h0000, mode_q} :
      rd_is_cfg  ? cfg_q[rd_ent] :
      rd_is_stat ? status_word : 32'h0000_0000;

   // Write address and data channels, taken in either order
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b1;
         aw_full_q     <= 1'b0;
         aw_addr_q     <= '0;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q     <= s_axi_awaddr;
            aw_full_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (do_write) begin
            aw_full_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_wready <= 1'b1;
         w_full_q     <= 1'b0;
         w_data_q     <= '0;
         w_strb_q     <= 4'h0;
      end else if (ce) begin
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_full_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (do_write) begin
            w_full_q <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // Write response; the status word accepts writes but ignores them
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `CWM_RESP_OKAY;
      end else if (ce) begin
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `CWM_RESP_OKAY : `CWM_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         mode_q <= `CWM_RST_MODE;
      end else if (ce && do_write && wr_hi_ok && wr_is_mode) begin
         mode_q <= mode_new & 16'(`CWM_MASK_MODE);
      end
   end

   // Configuration array, four entries per calendar
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         for (int k = 0; k < NUM_ENT; k++) begin
            cfg_q[k] <= `CWM_RST_CFG;
         end
      end else if (ce && do_write && wr_hi_ok && wr_is_cfg) begin
         cfg_q[wr_ent] <= cfg_new;
      end
   end

   // Read channel, one read at a time
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `CWM_RESP_OKAY;
      end else if (ce) begin
         if (do_read) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= rd_mapped ? `CWM_RESP_OKAY : `CWM_RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // Month length for the last-occurrence test; years 00..99 of one century
   function automatic logic [4:0] cwm_month_len(input logic [3:0] month, input logic [6:0] year);
      logic [4:0] len;
      len = 5'h1F;
      case (month)
         4'h2:    len = (year[1:0] == 2'h0) ? 5'h1D : 5'h1C;
         4'h4:    len = 5'h1E;
         4'h6:    len = 5'h1E;
         4'h9:    len = 5'h1E;
         4'hB:    len = 5'h1E;
         default: len = 5'h1F;
      endcase
      return len;
   endfunction

   wire logic [4:0]         days_in_month = cwm_month_len(now.month, now.year);
   wire logic [8:0]         date_key      = {now.month, now.day};
   wire logic               date_changed  = evaluated_q && (date_key != date_key_q);
   wire logic [NUM_CAL-1:0] today_sel_w;
   wire logic [NUM_CAL-1:0] active_w;
   // Previous day's selection must survive the date roll for midnight slots
   wire logic [NUM_CAL-1:0] yest_now      = date_changed ? today_sel_q : yest_sel_q;

   for (genvar i = 0; i < NUM_CAL; i++) begin : g_cal
      wire cwm_pkg::cwm_cal_cfg_t cal_cfg;
      assign cal_cfg.month_mask = cfg_q[4*i][11:0];
      assign cal_cfg.day_mask   = cfg_q[4*i+1];
      assign cal_cfg.start_time = cfg_q[4*i+2];
      assign cal_cfg.end_time   = cfg_q[4*i+3];
      cwm_cal_eval u_eval (
         .weekly        (mode_q[i]),
         .cfg           (cal_cfg),
         .now           (now),
         .days_in_month (days_in_month),
         .yest_sel      (yest_now[i]),
         .day_sel       (today_sel_w[i]),
         .active        (active_w[i])
      );
   end

   // Evaluated on every valid cycle, far more often than once a minute
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         calendar_active_terms <= '0;
         today_sel_q           <= '0;
         yest_sel_q            <= '0;
         date_key_q            <= 9'h000;
         evaluated_q           <= 1'b0;
      end else if (ce && time_valid) begin
         calendar_active_terms <= active_w;
         today_sel_q           <= today_sel_w;
         yest_sel_q            <= yest_now;
         date_key_q            <= date_key;
         evaluated_q           <= 1'b1;
      end
   end
endmodule

//--- cwm_top_sva.sv
`timescale 1ns/10ps
module cwm_top_sva #(
   parameter int NUM_CAL = 16,
   parameter int ADDR_W  = 16
) (
   input wire logic               ref_clk,
   input wire logic               rst_n,
   input wire logic               ce,
   input wire logic               s_axi_awvalid,
   input wire logic               s_axi_awready,
   input wire logic               s_axi_wvalid,
   input wire logic               s_axi_wready,
   input wire logic               s_axi_bvalid,
   input wire logic               s_axi_bready,
   input wire logic               s_axi_arvalid,
   input wire logic               s_axi_arready,
   input wire logic [31:0]        s_axi_rdata,
   input wire logic               s_axi_rvalid,
   input wire logic               s_axi_rready,
   input wire logic               time_valid,
   input wire logic [NUM_CAL-1:0] calendar_active_terms
);
   logic seen_q;
   // Holds when ce is low, though the design's reset acts regardless of ce
   always_ff @(posedge ref_clk) begin
      if (ce) seen_q <= rst_n && (seen_q || time_valid);
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_write_answer: assert property ((s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce) ##1 ce
      |=> s_axi_bvalid) else $error("write response late");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while busy");
   a_write_reopen: assert property (s_axi_bvalid && s_axi_bready && ce
      |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write channel not reopened");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid && !s_axi_arready)
      else $error("read response late");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   a_terms_reset: assert property (!seen_q |-> calendar_active_terms == '0)
      else $error("terms active before first evaluation");
   a_terms_change: assert property ($changed(calendar_active_terms) |-> $past(ce && time_valid))
      else $error("terms changed without a time sample");
   a_ce_freeze: assert property (!ce |=> $stable(calendar_active_terms))
      else $error("terms changed while enable low");
   c_write: cover property (s_axi_bvalid && s_axi_bready);
   c_read: cover property (s_axi_rvalid && s_axi_rready);
   c_active: cover property (calendar_active_terms != '0);
endmodule
bind cwm_top cwm_top_sva #(.NUM_CAL(NUM_CAL), .ADDR_W(ADDR_W)) u_sva (.ref_clk, .rst_n, .ce, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .time_valid, .calendar_active_terms);

//--- testbench.sv
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %h expected %h", $time, g, e); end end
module testbench;
   logic ref_clk = 0, rst_n = 0, ce = 1, time_valid = 0;
   logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   cwm_pkg::cwm_datetime_t now = '0;
   logic [15:0] terms;
   int error_cnt = 0, comparisons = 0;
   always #20 ref_clk = ~ref_clk;
   cwm_top uut (.ref_clk, .rst_n, .ce, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .time_valid, .now, .calendar_active_terms(terms));
   function automatic logic [15:0] ad(input int idx);
      return 16'(idx * 4);
   endfunction
   task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge ref_clk);
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      do begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      `CHK(s_axi_bresp, er)
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
      @(posedge ref_clk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      do begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      `CHK(s_axi_rdata, ed)
      `CHK(s_axi_rresp, er)
      s_axi_rready <= 0;
   endtask
   // Four entries per calendar: month, day, start, end
   task automatic cfg(input int c, input logic [31:0] m, dm, st, en);
      wr(ad(1901 + 4 * (c - 1)), m);
      wr(ad(1902 + 4 * (c - 1)), dm);
      wr(ad(1903 + 4 * (c - 1)), st);
      wr(ad(1904 + 4 * (c - 1)), en);
   endtask
   task automatic chk(input int c, input logic [6:0] y, input logic [3:0] mo, input logic [4:0] d,
                      input logic [2:0] wd, input logic [4:0] h, input logic [5:0] mi, input logic e);
      @(posedge ref_clk);
      now <= {y, mo, d, wd, h, mi};
      repeat (2) @(posedge ref_clk);
      `CHK(terms[c], e)
   endtask
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      stop_test;
   end
   initial begin
      repeat (10) @(posedge ref_clk);
      rst_n <= 1;
      `CHK(terms, 16'h0000)
      rd(ad(1899), 32'h0000_0000);
      rd(ad(1901), 32'h0000_0000);
      rd(16'h0000, 32'h0000_0000, 2'h2);
      wr(16'h0000, 32'hFFFF_FFFF, 2'h2);
      wr(ad(1899), 32'hFFFF_FFFF);
      rd(ad(1899), 32'h0000_0000);
      $display("test reset done");
      wr(ad(1900), 32'hFFFF_FFFF);
      rd(ad(1900), 32'h0000_FFFF);
      cfg(1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0000_0000);
      rd(ad(1901), 32'h0000_0FFF);
      rd(ad(1902), 32'h7FFF_FFFF);
      rd(ad(1903), 32'h0000_1F3F);
      // Only the low byte is enabled, the rest must survive
      s_axi_wstrb <= 4'h1;
      wr(ad(1902), 32'h0000_0000);
      s_axi_wstrb <= 4'hF;
      rd(ad(1902), 32'h7FFF_FF00);
      $display("test registers done");
      // Cal1 monthly, cal2/3/15/16 weekly
      wr(ad(1900), 32'h0000_C006);
      cfg(1, 32'h0000_0004, 32'h0000_0010, 32'h0000_0800, 32'h0000_1200);
      cfg(2, 32'h0000_0FFF, 32'h0040_0000, 32'h0000_0000, 32'h0000_0000);
      cfg(3, 32'h0000_0FFF, 32'h0004_0002, 32'h0000_0000, 32'h0000_0000);
      cfg(15, 32'h0000_0FFF, 32'h0002_0000, 32'h0000_1600, 32'h0000_0200);
      cfg(16, 32'h0000_0FFF, 32'h0001_0010, 32'h0000_0000, 32'h0000_0000);
      time_valid <= 1;
      chk(0, 23, 3, 5, 0, 9, 0, 1);
      chk(0, 23, 3, 5, 0, 7, 59, 0);
      chk(0, 23, 3, 5, 0, 8, 0, 1);
      chk(0, 23, 3, 5, 0, 18, 0, 0);
      chk(0, 23, 4, 5, 0, 9, 0, 0);
      chk(0, 23, 3, 6, 0, 9, 0, 0);
      chk(1, 23, 3, 25, 6, 12, 0, 1);
      chk(1, 23, 3, 24, 5, 12, 0, 0);
      chk(2, 23, 5, 9, 2, 12, 0, 1);
      chk(2, 23, 5, 16, 2, 12, 0, 0);
      chk(15, 23, 10, 29, 0, 0, 0, 1);
      chk(15, 23, 10, 22, 0, 23, 59, 0);
      chk(15, 23, 2, 26, 0, 12, 0, 1);
      chk(15, 24, 2, 22, 0, 12, 0, 0);
      chk(15, 24, 2, 29, 0, 12, 0, 1);
      chk(14, 23, 1, 2, 1, 23, 0, 1);
      chk(14, 23, 1, 3, 2, 1, 0, 1);
      chk(14, 23, 1, 3, 2, 3, 0, 0);
      chk(14, 23, 1, 2, 1, 21, 0, 0);
      $display("test calendars done");
      // Terms must hold while the time input is invalid
      time_valid <= 0;
      chk(0, 23, 3, 5, 0, 9, 0, 0);
      time_valid <= 1;
      repeat (2) @(posedge ref_clk);
      `CHK(terms, 16'h0001)
      rd(ad(1899), 32'h0001_0001);
      $display("test hold done");
      // Frozen while the enable is low, catches up once it returns
      ce <= 0;
      chk(0, 23, 4, 5, 0, 9, 0, 1);
      ce <= 1;
      repeat (2) @(posedge ref_clk);
      `CHK(terms[0], 1'b0)
      $display("test enable done");
      stop_test;
   end
endmodule
